// *** src/pfk_pkg.sv ***
// Package for the panel function-key controller: register map, field positions,
// reset values, command codes and the change-window timing.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
package pfk_pkg;

  // ********************************************************************
  // Register offsets (byte addresses).
  // ********************************************************************
  localparam logic [11:0] OFS_STATE    = 12'h000;  // Function and profile state, read only.
  localparam logic [11:0] OFS_CMD      = 12'h004;  // Configuration-software command, write only.
  localparam logic [11:0] OFS_PROF_CFG = 12'h008;  // Per-profile switches and counts.
  localparam logic [11:0] OFS_HCL_TRIP = 12'h00C;  // Per-profile lockout trip numbers.
  localparam logic [11:0] OFS_USER_LED = 12'h010;  // User-key lamp conditions.

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int ST_GND    = 0;   // Ground trip block state bit.
  localparam int ST_NREC   = 1;   // Reclose inhibit state bit.
  localparam int ST_SUPOFF = 2;   // Remote command lockout state bit.
  localparam int ST_PROF   = 3;   // Two-bit active profile field, 0 is normal.
  localparam int ST_ARMED  = 5;   // Change window armed, in the status word only.
  localparam int ST_TAG    = 6;   // Live-work tag, in the status word only.
  localparam int CMD_OP    = 0;   // Three-bit command code field.
  localparam int CMD_VAL   = 8;   // Two-bit command value field.
  localparam int CFG_SEQ   = 0;   // Four sequence-coordination enables.
  localparam int CFG_FTD   = 4;   // Four fast-trip-disable enables.
  localparam int CFG_HCL   = 8;   // Four high-current-lockout enables.
  localparam int CFG_SCNT  = 12;  // Four two-bit sequence counts.

  // ********************************************************************
  // Key indices on the synchronised panel vector.
  // ********************************************************************
  localparam int K_GND = 0;   // Ground trip block key.
  localparam int K_NREC = 1;  // Reclose inhibit key.
  localparam int K_SUP = 2;   // Remote command lockout key.
  localparam int K_ALT1 = 3;  // First alternate profile key; two more follow.
  localparam int K_OPT1 = 6;  // First user key; two more follow.
  localparam int K_CHG = 9;   // Change key.
  localparam int K_TRIP = 10; // Trip pushbutton.
  localparam int K_CLOSE = 11; // Close pushbutton.
  localparam int K_TAG = 12;  // Live-work tag switch.

  // ********************************************************************
  // Command codes shared by panel, remote and software sources.
  // ********************************************************************
  localparam logic [2:0] OP_NONE   = 3'h0;  // No command.
  localparam logic [2:0] OP_GND    = 3'h1;  // Set ground trip block to value bit 0.
  localparam logic [2:0] OP_NREC   = 3'h2;  // Set reclose inhibit to value bit 0.
  localparam logic [2:0] OP_SUPOFF = 3'h3;  // Set lockout; accepted from the panel only.
  localparam logic [2:0] OP_PROF   = 3'h4;  // Select profile given by value.

  // ********************************************************************
  // Reset values.
  // ********************************************************************
  localparam logic [4:0]  RST_STATE    = 5'h00;      // All functions off, normal profile.
  localparam logic [19:0] RST_PROF_CFG = 20'h55000;  // Counts of one, all switches off.
  localparam logic [23:0] RST_HCL_TRIP = 24'h000000; // Lockout on first trip everywhere.
  localparam logic [2:0]  RST_USER_LED = 3'h0;       // User lamps dark.

  // ********************************************************************
  // Change-window timing.
  // ********************************************************************
  localparam int CHANGE_WIN_S  = 10;           // Window length in seconds.
  localparam int CLK_HZ        = 100_000_000;  // pclk rate in hertz.
  localparam int CHANGE_WIN_CYC = CHANGE_WIN_S * CLK_HZ;  // Window in pclk cycles.

  // Change-window states, Gray coded.
  typedef enum logic {
    PFK_IDLE  = 1'b0,
    PFK_ARMED = 1'b1
  } pfk_state_t;

endpackage : pfk_pkg

// *** src/pfk_ctrl.sv ***
// Panel function-key and protection-mode controller with an APB register slave.
// Assumes panel keys and the tag switch are asynchronous pins, remote commands and
// current comparators come from logic on pclk, and the bus master follows APB.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module pfk_ctrl #(
  parameter int unsigned CHANGE_WIN_CYCLES = pfk_pkg::CHANGE_WIN_CYC  // Window length.
) (
  input  wire logic        pclk,              // Bus and block clock.
  input  wire logic        presetn,           // Asynchronous reset, active low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB access phase.
  input  wire logic        pwrite,            // APB direction, high for write.
  input  wire logic [11:0] paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error on unmapped address.
  input  wire logic [12:0] panel_in,          // Raw keys, change, trip, close, tag.
  input  wire logic        remote_cmd_valid,  // Rear serial or discrete command strobe.
  input  wire logic [2:0]  remote_cmd_op,     // Remote command code.
  input  wire logic [1:0]  remote_cmd_val,    // Remote command value.
  input  wire logic [2:0]  over_level,        // Current above level: phase, ground, neg.
  input  wire logic [1:0]  trip_number,       // Zero-based number of the coming trip.
  output logic [8:0]       lamp,              // Function-key lamps.
  output logic [2:0]       user_key_pulse,    // One-cycle user key pulses.
  output logic             remote_cmd_reject, // Pulse when a remote command is refused.
  output logic [1:0]       active_profile,    // Zero normal, one to three alternates.
  output logic             gnd_sense_block,   // Ground sensing suppressed.
  output logic             reclose_block,     // Automatic reclosing suppressed.
  output logic             close_block,       // Every closing attempt blocked.
  output logic             delayed_curve,     // Trips time on the delayed curve.
  output logic             seq_coord_en,      // Sequence coordination on.
  output logic [1:0]       seq_coord_count,   // Advances allowed, one to three.
  output logic             hcl_lockout,       // Pulse to lock out on high current.
  output logic             trip_req,          // Panel trip request pulse.
  output logic             close_req          // Panel close request pulse.
);

  // ********************************************************************
  // Helper functions.
  // ********************************************************************

  // Applies one command to the state word; lockout is handled by the caller.
  function automatic logic [4:0] pfk_apply(input logic [4:0] st, input logic [2:0] op,
                                           input logic [1:0] val);
    logic [4:0] r;
    r = st;
    unique case (op)
      pfk_pkg::OP_GND:    r[pfk_pkg::ST_GND] = val[0];
      pfk_pkg::OP_NREC:   r[pfk_pkg::ST_NREC] = val[0];
      pfk_pkg::OP_SUPOFF: r[pfk_pkg::ST_SUPOFF] = val[0];
      pfk_pkg::OP_PROF:   r[pfk_pkg::ST_PROF +: 2] = val;  // Always one profile.
      default:            r = st;
    endcase
    return r;
  endfunction : pfk_apply

  // Returns the lowest pressed function key among 0..5, or 15 when none.
  function automatic logic [3:0] pfk_first(input logic [5:0] k);
    logic [3:0] r;
    r = 4'hF;
    for (int i = 5; i >= 0; i--) begin
      if (k[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : pfk_first

  // ********************************************************************
  // Declarations.
  // ********************************************************************
  logic [12:0]        sync1_r;       // First synchroniser stage.
  logic [12:0]        sync2_r;       // Second synchroniser stage.
  logic [12:0]        prev_r;        // Delayed copy for edge detection.
  logic [12:0]        press;         // Rising edges of synchronised inputs.
  pfk_pkg::pfk_state_t mode_r;       // Change-window state.
  pfk_pkg::pfk_state_t mode_nxt;     // Next change-window state.
  logic [29:0]        win_cnt_r;     // Cycles left in the change window.
  logic [4:0]         st_r;          // Function and profile state.
  logic [4:0]         st_nxt;        // Next state after all sources.
  logic [4:0]         st_panel;      // State after the panel toggle.
  logic [2:0]         pan_op;        // Panel command code.
  logic [1:0]         pan_val;       // Panel command value.
  logic [3:0]         key_idx;       // Chosen function key.
  logic               remote_ok;     // Remote command accepted.
  logic               wr_en;         // APB write in the access phase.
  logic               rd_setup;      // APB read in the setup phase.
  logic               addr_ok;       // Address decodes to a register.
  logic [19:0]        prof_cfg_r;    // Profile switch register.
  logic [23:0]        hcl_trip_r;    // Lockout trip number register.
  logic [2:0]         user_led_r;    // User lamp register.
  logic [31:0]        prdata_r;      // Read data register.
  logic [2:0]         user_pulse_r;  // User key pulse register.
  logic               reject_r;      // Remote reject pulse register.
  logic               hcl_r;         // High-current lockout pulse register.
  logic [1:0]         trip_close_r;  // Trip and close pulse registers.
  logic [1:0]         prof;          // Active profile index.
  logic [2:0]         hcl_hit;       // Per-quantity lockout match.

  // ********************************************************************
  // Input synchronisers and edge detection.
  // ********************************************************************

  // Two stages for every pin, then a third copy for edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 13'h0000;
      sync2_r <= 13'h0000;
      prev_r  <= 13'h0000;
    end else begin
      sync1_r <= panel_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // A press is a rising edge of the second stage.
  assign press = sync2_r & ~prev_r;

  // ********************************************************************
  // Change window.
  // ********************************************************************

  // The lowest pressed key wins when several rise together.
  assign key_idx = pfk_first(press[5:0]);

  // Next window state: arm on change, drop on a toggle or on timeout.
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      pfk_pkg::PFK_IDLE: begin
        if (press[pfk_pkg::K_CHG]) begin
          mode_nxt = pfk_pkg::PFK_ARMED;
        end
      end
      pfk_pkg::PFK_ARMED: begin
        if (press[pfk_pkg::K_CHG]) begin
          mode_nxt = pfk_pkg::PFK_ARMED;  // A new change press re-arms the window.
        end else if (key_idx != 4'hF) begin
          mode_nxt = pfk_pkg::PFK_IDLE;
        end else if (win_cnt_r == 30'h0) begin
          mode_nxt = pfk_pkg::PFK_IDLE;
        end
      end
    endcase
  end

  // State register of the change window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= pfk_pkg::PFK_IDLE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Timer reloads on every change press and counts down while armed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= 30'h0;
    end else if (press[pfk_pkg::K_CHG]) begin
      win_cnt_r <= 30'(CHANGE_WIN_CYCLES - 1);
    end else if (mode_r == pfk_pkg::PFK_ARMED && win_cnt_r != 30'h0) begin
      win_cnt_r <= win_cnt_r - 30'h1;
    end
  end

  // ********************************************************************
  // Command sources.
  // ********************************************************************

  // Panel key turns into a command only inside an armed window.
  always_comb begin
    pan_op  = pfk_pkg::OP_NONE;
    pan_val = 2'h0;
    if (mode_r == pfk_pkg::PFK_ARMED && !press[pfk_pkg::K_CHG] && key_idx != 4'hF) begin
      unique case (key_idx)
        4'h0: begin
          pan_op  = pfk_pkg::OP_GND;
          pan_val = {1'b0, ~st_r[pfk_pkg::ST_GND]};
        end
        4'h1: begin
          pan_op  = pfk_pkg::OP_NREC;
          pan_val = {1'b0, ~st_r[pfk_pkg::ST_NREC]};
        end
        4'h2: begin
          pan_op  = pfk_pkg::OP_SUPOFF;
          pan_val = {1'b0, ~st_r[pfk_pkg::ST_SUPOFF]};
        end
        default: begin
          // Alternate keys: reselecting the active one returns to normal.
          pan_op  = pfk_pkg::OP_PROF;
          pan_val = (prof == 2'(key_idx - 4'h2)) ? 2'h0 : 2'(key_idx - 4'h2);
        end
      endcase
    end
  end

  // Rear serial and discrete commands are refused under lockout.
  assign remote_ok = remote_cmd_valid && !st_r[pfk_pkg::ST_SUPOFF]
                     && remote_cmd_op != pfk_pkg::OP_SUPOFF;

  // Panel first, then remote, then the configuration port.
  always_comb begin
    st_panel = pfk_apply(st_r, pan_op, pan_val);
    st_nxt   = st_panel;
    if (remote_ok) begin
      st_nxt = pfk_apply(st_nxt, remote_cmd_op, remote_cmd_val);
    end
    // Front configuration port ignores lockout but may not set it.
    if (wr_en && paddr == pfk_pkg::OFS_CMD
        && pwdata[pfk_pkg::CMD_OP +: 3] != pfk_pkg::OP_SUPOFF) begin
      st_nxt = pfk_apply(st_nxt, pwdata[pfk_pkg::CMD_OP +: 3],
                         pwdata[pfk_pkg::CMD_VAL +: 2]);
    end
  end

  // Function state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= pfk_pkg::RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************************
  // APB slave.
  // ********************************************************************
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok  = paddr == pfk_pkg::OFS_STATE || paddr == pfk_pkg::OFS_CMD
                    || paddr == pfk_pkg::OFS_PROF_CFG || paddr == pfk_pkg::OFS_HCL_TRIP
                    || paddr == pfk_pkg::OFS_USER_LED;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;

  // Writable configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prof_cfg_r <= pfk_pkg::RST_PROF_CFG;
      hcl_trip_r <= pfk_pkg::RST_HCL_TRIP;
      user_led_r <= pfk_pkg::RST_USER_LED;
    end else if (wr_en) begin
      if (paddr == pfk_pkg::OFS_PROF_CFG) begin
        prof_cfg_r <= pwdata[19:0];
      end
      if (paddr == pfk_pkg::OFS_HCL_TRIP) begin
        hcl_trip_r <= pwdata[23:0];
      end
      if (paddr == pfk_pkg::OFS_USER_LED) begin
        user_led_r <= pwdata[2:0];
      end
    end
  end

  // Read data is captured in the setup phase; unmapped and write-only read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        pfk_pkg::OFS_STATE:    prdata_r <= {25'h0, sync2_r[pfk_pkg::K_TAG],
                                            mode_r == pfk_pkg::PFK_ARMED, st_r};
        pfk_pkg::OFS_PROF_CFG: prdata_r <= {12'h000, prof_cfg_r};
        pfk_pkg::OFS_HCL_TRIP: prdata_r <= {8'h00, hcl_trip_r};
        pfk_pkg::OFS_USER_LED: prdata_r <= {29'h0, user_led_r};
        default:               prdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_r;

  // ********************************************************************
  // Lamps and mode outputs.
  // ********************************************************************
  assign prof = st_r[pfk_pkg::ST_PROF +: 2];

  // Lamps follow state, not which source set it.
  assign lamp[pfk_pkg::K_GND]  = st_r[pfk_pkg::ST_GND];
  assign lamp[pfk_pkg::K_NREC] = st_r[pfk_pkg::ST_NREC];
  assign lamp[pfk_pkg::K_SUP]  = st_r[pfk_pkg::ST_SUPOFF];
  assign lamp[5:3]             = {prof == 2'h3, prof == 2'h2, prof == 2'h1};
  assign lamp[8:6]             = user_led_r;

  assign active_profile  = prof;
  assign gnd_sense_block = st_r[pfk_pkg::ST_GND];
  // The tag blocks closing and so overrides reclose inhibit too.
  assign reclose_block   = st_r[pfk_pkg::ST_NREC] | sync2_r[pfk_pkg::K_TAG];
  assign close_block     = sync2_r[pfk_pkg::K_TAG];
  // Curve choice ignores reclose inhibit; the tag forces the fast curve.
  assign delayed_curve   = prof_cfg_r[pfk_pkg::CFG_FTD + prof] & ~sync2_r[pfk_pkg::K_TAG];
  assign seq_coord_en    = prof_cfg_r[pfk_pkg::CFG_SEQ + prof];
  // A stored zero count reads as one, keeping the range one to three.
  assign seq_coord_count = (prof_cfg_r[pfk_pkg::CFG_SCNT + 2 * prof +: 2] == 2'h0)
                           ? 2'h1 : prof_cfg_r[pfk_pkg::CFG_SCNT + 2 * prof +: 2];

  // ********************************************************************
  // Pulses: user keys, trip and close, lockout, remote reject.
  // ********************************************************************

  // Each quantity matches when above level on its selected trip.
  always_comb begin
    for (int q = 0; q < 3; q++) begin
      hcl_hit[q] = over_level[q] && trip_number == hcl_trip_r[6 * prof + 2 * q +: 2];
    end
  end

  // Registered pulse outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_pulse_r <= 3'h0;
      reject_r     <= 1'b0;
      hcl_r        <= 1'b0;
      trip_close_r <= 2'h0;
    end else begin
      user_pulse_r <= press[pfk_pkg::K_OPT1 +: 3];
      reject_r     <= remote_cmd_valid && !remote_ok;
      hcl_r        <= prof_cfg_r[pfk_pkg::CFG_HCL + prof] && (|hcl_hit);
      // Trip and close bypass lockout; a close press is dropped while the tag is on.
      trip_close_r <= {press[pfk_pkg::K_CLOSE] & ~sync2_r[pfk_pkg::K_TAG],
                       press[pfk_pkg::K_TRIP]};
    end
  end

  assign user_key_pulse    = user_pulse_r;
  assign remote_cmd_reject = reject_r;
  assign hcl_lockout       = hcl_r;
  assign trip_req          = trip_close_r[0];
  assign close_req         = trip_close_r[1];

endmodule : pfk_ctrl

// *** testbench/pfk_ctrl_chk.sv ***
// Port checker for the panel function-key controller.
// Assumes it is bound to pfk_ctrl and sees only its ports.
`timescale 1ns/10ps
module pfk_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [12:0] panel_in,
  input wire logic        remote_cmd_valid,
  input wire logic [2:0]  remote_cmd_op,
  input wire logic [2:0]  over_level,
  input wire logic [8:0]  lamp,
  input wire logic [2:0]  user_key_pulse,
  input wire logic        remote_cmd_reject,
  input wire logic [1:0]  active_profile,
  input wire logic        gnd_sense_block,
  input wire logic        reclose_block,
  input wire logic        close_block,
  input wire logic        delayed_curve,
  input wire logic [1:0]  seq_coord_count,
  input wire logic        hcl_lockout,
  input wire logic        close_req
);
  // All checks run on pclk and rest while reset is applied.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_prof_lamp: assert property ((lamp[3] == (active_profile == 2'h1)) &&
    (lamp[5] == (active_profile == 2'h3))) else $error("profile lamp wrong");
  a_one_prof: assert property ($onehot0(lamp[5:3])) else $error("two profiles lit");
  a_gnd_lamp: assert property (lamp[0] == gnd_sense_block) else $error("ground lamp");
  a_nrec_lamp: assert property (lamp[1] |-> reclose_block) else $error("reclose lamp");
  a_lock_rej: assert property (remote_cmd_valid && (lamp[2] || remote_cmd_op == 3'h3)
    |=> remote_cmd_reject) else $error("remote not refused");
  a_user_pulse: assert property ((user_key_pulse & $past(user_key_pulse)) == 3'h0)
    else $error("user pulse too long");
  a_tag_close: assert property (panel_in[12] [*5] |-> close_block && reclose_block &&
    !delayed_curve && !close_req) else $error("tag override");
  a_seq_cnt: assert property (seq_coord_count != 2'h0) else $error("sequence count zero");
  a_hcl_quiet: assert property (over_level == 3'h0 |=> !hcl_lockout)
    else $error("lockout without current");
endmodule : pfk_ctrl_chk

bind pfk_ctrl pfk_ctrl_chk pfk_ctrl_chk_inst (.pclk, .presetn, .panel_in, .remote_cmd_valid,
  .remote_cmd_op, .over_level, .lamp, .user_key_pulse, .remote_cmd_reject, .active_profile,
  .gnd_sense_block, .reclose_block, .close_block, .delayed_curve, .seq_coord_count,
  .hcl_lockout, .close_req);

// *** testbench/pfk_panel_model.sv ***
// Front-panel operator model: presses keys and works the tag switch.
// Assumes the bench supplies pclk; pins change just after rising edges.
`timescale 1ns/10ps
module pfk_panel_model (
  input  wire logic        pclk,
  output logic      [12:0] panel_in
);
  initial panel_in = 13'h0000;
  // Holds one key for hold cycles, then waits for the press to take effect.
  task automatic press(input int k, input int hold);
    @(posedge pclk);
    panel_in[k] <= 1'b1;
    repeat (hold) @(posedge pclk);
    panel_in[k] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : press
  // Moves the live-work tag switch.
  task automatic tag(input logic on);
    @(posedge pclk);
    panel_in[12] <= on;
  endtask : tag
endmodule : pfk_panel_model

// *** testbench/test_panel_function_key_control.sv ***
// Self-checking bench for pfk_ctrl with a panel model and an APB master.
// Assumes a 50-cycle change window so that timeouts stay short.
`timescale 1ns/10ps
module test_panel_function_key_control;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rv = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rej, cb_o, dc, tr, cr, hl;
  logic [2:0] ol = 3'h0;
  int ntr = 0, ncr = 0, nhl = 0;
  logic [2:0] rop = 3'h0, ukp;
  logic [1:0] rval = 2'h0, ap, p;
  logic [12:0] pin;
  logic [8:0] lamp;
  logic [15:0] lf = 16'h6DB2;
  int n_fail = 0, checks_done = 0, cyc = 0, nuk = 0, i;
  always #5 pclk = ~pclk;
  pfk_panel_model pfk_panel_model_inst (.pclk(pclk), .panel_in(pin));
  pfk_ctrl #(.CHANGE_WIN_CYCLES(50)) pfk_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .panel_in(pin), .remote_cmd_valid(rv),
    .remote_cmd_op(rop), .remote_cmd_val(rval), .over_level(ol), .trip_number(2'h0), .lamp,
    .user_key_pulse(ukp), .remote_cmd_reject(rej), .active_profile(ap), .gnd_sense_block(),
    .reclose_block(), .close_block(cb_o), .delayed_curve(dc), .seq_coord_en(),
    .seq_coord_count(), .hcl_lockout(hl), .trip_req(tr), .close_req(cr));
  // Cuts a hang short and counts first user key, trip, close and lockout pulses.
  always @(posedge pclk) begin
    cyc++;
    if (ukp[0] === 1'b1) nuk++;
    if (tr === 1'b1) ntr++;
    if (cr === 1'b1) ncr++;
    if (hl === 1'b1) nhl++;
    if (cyc == 6000) begin
      n_fail++;
      wrap_up();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // Expected status word from the function states.
  function automatic logic [31:0] st(input logic g, n, s, input logic [1:0] pr);
    return {27'h0, pr, s, n, g};
  endfunction : st
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee, string m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, m);
    chk({31'h0, e}, {31'h0, ee}, m);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rem(input logic [2:0] op, input logic [1:0] v);
    @(posedge pclk);
    rv <= 1'b1;
    rop <= op;
    rval <= v;
    @(posedge pclk);
    rv <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : rem
  task automatic key(input int k);
    lf = lfsr(lf);
    pfk_panel_model_inst.press(k, 2 + int'(lf[1:0]));
  endtask : key
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(pfk_pkg::OFS_STATE, 32'h0, 1'b0, "reset state");
    rd(pfk_pkg::OFS_PROF_CFG, 32'h55000, 1'b0, "reset cfg");
    rd(pfk_pkg::OFS_HCL_TRIP, 32'h0, 1'b0, "reset trip");
    rd(12'h020, 32'h0, 1'b1, "unmapped");
    key(pfk_pkg::K_NREC);
    rd(pfk_pkg::OFS_STATE, 32'h0, 1'b0, "unarmed key");
    key(pfk_pkg::K_CHG);
    key(pfk_pkg::K_GND);
    key(pfk_pkg::K_NREC);
    rd(pfk_pkg::OFS_STATE, st(1, 0, 0, 0), 1'b0, "one change");
    key(pfk_pkg::K_CHG);
    repeat (60) @(posedge pclk);
    key(pfk_pkg::K_GND);
    rd(pfk_pkg::OFS_STATE, st(1, 0, 0, 0), 1'b0, "expired window");
    $display("test panel window done");
    for (i = 1; i < 4; i++) begin
      key(pfk_pkg::K_CHG);
      key(pfk_pkg::K_ALT1 + i - 1);
      rd(pfk_pkg::OFS_STATE, st(1, 0, 0, i[1:0]), 1'b0, "alt select");
      key(pfk_pkg::K_CHG);
      key(pfk_pkg::K_ALT1 + i - 1);
      rd(pfk_pkg::OFS_STATE, st(1, 0, 0, 0), 1'b0, "alt deselect");
    end
    $display("test profiles done");
    rem(pfk_pkg::OP_SUPOFF, 2'h1);
    key(pfk_pkg::K_CHG);
    key(pfk_pkg::K_SUP);
    rem(pfk_pkg::OP_GND, 2'h0);
    rd(pfk_pkg::OFS_STATE, st(1, 0, 1, 0), 1'b0, "locked remote");
    key(pfk_pkg::K_TRIP);
    chk(ntr, 1, "trip under lockout");
    wr(pfk_pkg::OFS_CMD, 32'h1);
    wr(pfk_pkg::OFS_CMD, 32'h103);
    rd(pfk_pkg::OFS_STATE, st(0, 0, 1, 0), 1'b0, "front port");
    key(pfk_pkg::K_CHG);
    key(pfk_pkg::K_SUP);
    $display("test lockout done");
    for (i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      p = lf[1:0];
      rem(pfk_pkg::OP_PROF, p);
      rd(pfk_pkg::OFS_STATE, st(0, 0, 0, p), 1'b0, "remote profile");
    end
    rem(pfk_pkg::OP_NREC, 2'h1);
    rd(pfk_pkg::OFS_STATE, st(0, 1, 0, p), 1'b0, "remote inhibit");
    key(pfk_pkg::K_OPT1);
    chk(nuk, 1, "user pulse");
    wr(pfk_pkg::OFS_PROF_CFG, 32'h55000 | (32'h110 << p));
    repeat (2) @(posedge pclk);
    chk({31'h0, dc}, 32'h1, "delayed curve");
    ol <= 3'h1;
    @(posedge pclk);
    ol <= 3'h0;
    repeat (3) @(posedge pclk);
    chk(nhl, 1, "high current lockout");
    pfk_panel_model_inst.tag(1'b1);
    key(pfk_pkg::K_CLOSE);
    chk({30'h0, cb_o, dc}, 32'h2, "tag override");
    chk(ncr, 0, "close under tag");
    pfk_panel_model_inst.tag(1'b0);
    $display("test modes done");
    wrap_up();
  end
endmodule : test_panel_function_key_control
